// file: verilog/cssr_pkg.sv
// Constants and types for the channel sequence stack register bank.
`default_nettype none

package cssr_pkg;

	// ------------------------------------------------------------------
	// Widths and stack geometry
	// ------------------------------------------------------------------
	localparam int unsigned DATA_W      = 16;
	localparam int unsigned ADDR_W      = 6;
	localparam int unsigned PTR_W       = 5;
	localparam int unsigned STACK_DEPTH = 32;
	localparam int unsigned BANK_N      = 4;
	localparam int unsigned ENTRY_W     = 9;
	localparam int unsigned CHAN_W      = 4;

	// Stack index of the first entry held in this bank.
	localparam logic [PTR_W-1:0] BANK_FIRST = 5'h06;
	localparam logic [PTR_W-1:0] BANK_LAST  = 5'h09;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_STEP_SIX   = 6'h26;
	localparam logic [ADDR_W-1:0] OFF_STEP_SEVEN = 6'h27;
	localparam logic [ADDR_W-1:0] OFF_STEP_EIGHT = 6'h28;
	localparam logic [ADDR_W-1:0] OFF_STEP_NINE  = 6'h29;
	localparam logic [ADDR_W-1:0] OFF_STATUS     = 6'h30;

	// ------------------------------------------------------------------
	// Field positions of a stack word
	// ------------------------------------------------------------------
	localparam int unsigned DIR_BIT   = 15;
	localparam int unsigned TADDR_HI  = 14;
	localparam int unsigned TADDR_LO  = 9;
	localparam int unsigned RET_BIT   = 8;
	localparam int unsigned CHB_HI    = 7;
	localparam int unsigned CHB_LO    = 4;
	localparam int unsigned CHA_HI    = 3;
	localparam int unsigned CHA_LO    = 0;
	localparam logic        DIR_READ  = 1'b0;
	localparam logic        DIR_WRITE = 1'b1;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_STEP_SIX   = 16'h4c66;
	localparam logic [DATA_W-1:0] RST_STEP_SEVEN = 16'h4f77;
	localparam logic [DATA_W-1:0] RST_STEP_EIGHT = 16'h5000;
	localparam logic [DATA_W-1:0] RST_STEP_NINE  = 16'h5200;
	localparam logic [DATA_W-1:0] RST_VALS [BANK_N] = '{
		RST_STEP_SIX, RST_STEP_SEVEN, RST_STEP_EIGHT, RST_STEP_NINE
	};

	// Stored part of a stack entry: return flag and both channel selects.
	typedef logic [ENTRY_W-1:0] cssr_entry_t;

endpackage : cssr_pkg

`default_nettype wire

// file: verilog/cssr_step_if.sv
// Interface between the register bank and its stack pointer.
`default_nettype none

interface cssr_step_if;
	import cssr_pkg::*;

	logic             conv_done;
	logic             return_flag;
	logic [PTR_W-1:0] ptr;

	modport ptr_end (input conv_done, input return_flag, output ptr);
	modport bank_end (output conv_done, output return_flag, input ptr);

endinterface : cssr_step_if

`default_nettype wire

// file: verilog/cssr_step_ptr.sv
// Sequencer stack pointer that steps or wraps as conversions finish.
`default_nettype none

module cssr_step_ptr #(
	parameter int unsigned DEPTH = cssr_pkg::STACK_DEPTH
) (
	input  wire logic      clock_i,
	input  wire logic      reset_i,
	cssr_step_if.ptr_end   step
);
	import cssr_pkg::*;

	logic [PTR_W-1:0] ptr_r;
	logic [PTR_W-1:0] ptr_nxt;

	// ------------------------------------------------------------------
	// Next pointer
	// ------------------------------------------------------------------
	// The last stack slot wraps even with a clear flag, so the pointer
	// can never run past the stack.
	always_comb begin
		ptr_nxt = ptr_r;
		if (step.conv_done) begin
			if (step.return_flag || ptr_r == PTR_W'(DEPTH - 1)) begin
				ptr_nxt = '0;
			end else begin
				ptr_nxt = ptr_r + 5'h01;
			end
		end
	end

	// Pointer register, starting at the first entry.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ptr_r <= '0;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	assign step.ptr = ptr_r;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence done_keep_s;
		step.conv_done && !step.return_flag && ptr_r != PTR_W'(DEPTH - 1);
	endsequence

	step_advance_a: assert property (@(posedge clock_i) disable iff (reset_i)
		done_keep_s |=> ptr_r == $past(ptr_r) + 5'h01)
		else $error("Pointer did not advance after a conversion.");

	step_wrap_a: assert property (@(posedge clock_i) disable iff (reset_i)
		step.conv_done && step.return_flag |=> ptr_r == '0)
		else $error("Pointer did not return to the first entry.");

	ptr_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
		!step.conv_done |=> $stable(ptr_r))
		else $error("Pointer moved without a finished conversion.");

	ptr_reset_a: assert property (@(posedge clock_i)
		reset_i |=> ptr_r == '0)
		else $error("Pointer not at the first entry after reset.");

endmodule : cssr_step_ptr

`default_nettype wire

// file: verilog/cssr_regs.sv
// Register bank for sequencer stack steps six to nine, with the step pointer.
`default_nettype none

// Function
// - Bit 15 of a stack word picks the direction: 0 asks to read the register, 1 to write it.
// - Bits 14-9 must hold the register's own address to reach it, and read back as that address.
// - With the return flag (bit 8) of the current entry clear, the pointer steps on after a conversion, except from the last stack slot, which wraps to the first.
// - With the return flag of the current entry set, the pointer goes back to the first entry.
// - Bits 7-4 of the current entry choose the channel sampled by converter B.
// - Bits 3-0 of the current entry choose the channel sampled by converter A.
// - Step seven resets to 0x4f77, return flag set and both channel selects 7.
// - Steps eight and nine reset to 0x5000 and 0x5200, flag clear and channels zero.
module cssr_regs (
	input  wire logic                          clock_i,
	input  wire logic                          reset_i,
	input  wire logic [cssr_pkg::ADDR_W-1:0]   reg_addr_i,
	input  wire logic [cssr_pkg::DATA_W-1:0]   reg_wdata_i,
	input  wire logic                          reg_write_i,
	input  wire logic                          reg_read_i,
	output logic      [cssr_pkg::DATA_W-1:0]   reg_rdata_o,
	input  wire logic                          conversion_done_i,
	input  wire logic                          other_return_flag_i,
	input  wire logic [cssr_pkg::CHAN_W-1:0]   other_chan_a_i,
	input  wire logic [cssr_pkg::CHAN_W-1:0]   other_chan_b_i,
	output logic      [cssr_pkg::PTR_W-1:0]    stack_pointer_o,
	output logic      [cssr_pkg::CHAN_W-1:0]   converter_a_channel_select_o,
	output logic      [cssr_pkg::CHAN_W-1:0]   converter_b_channel_select_o,
	output logic                               address_mismatch_o
);
	import cssr_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	cssr_entry_t         entry_r [BANK_N];
	logic [DATA_W-1:0]   rdata_r;
	logic [CHAN_W-1:0]   chan_a_r;
	logic [CHAN_W-1:0]   chan_b_r;
	logic                mismatch_r;
	logic                bank_hit;
	logic [1:0]          bank_sel;
	logic                field_ok;
	logic                wr_cmd;
	logic                rd_frame;
	logic                rd_any;
	logic                bad_frame;
	logic                ptr_in_bank;
	logic [1:0]          ptr_sel;
	cssr_entry_t         cur_entry;
	logic [PTR_W-1:0]    ptr;

	cssr_step_if step ();

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// A stack word only lands when the address field inside it names the
	// addressed register; this guards against a host writing a word that
	// was built for another step.
	assign bank_hit  = reg_addr_i >= OFF_STEP_SIX && reg_addr_i <= OFF_STEP_NINE;
	assign bank_sel  = 2'(reg_addr_i - OFF_STEP_SIX);
	assign field_ok  = reg_wdata_i[TADDR_HI:TADDR_LO] == reg_addr_i;
	assign wr_cmd    = reg_write_i && bank_hit && field_ok
		&& reg_wdata_i[DIR_BIT] == DIR_WRITE;
	assign rd_frame  = reg_write_i && bank_hit && field_ok
		&& reg_wdata_i[DIR_BIT] == DIR_READ;
	assign rd_any    = reg_read_i || rd_frame;
	assign bad_frame = reg_write_i && bank_hit && !field_ok;

	// ------------------------------------------------------------------
	// Stack entries
	// ------------------------------------------------------------------
	// Only the flag and channel fields are stored; the direction bit and
	// the address field are fixed and rebuilt on read.
	for (genvar g = 0; g < BANK_N; g++) begin : g_entry
		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				entry_r[g] <= RST_VALS[g][ENTRY_W-1:0];
			end else if (wr_cmd && bank_sel == 2'(g)) begin
				entry_r[g] <= reg_wdata_i[ENTRY_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// Read data stand for one cycle only and are zero otherwise, so a
	// stale word never looks like a fresh answer. Unmapped reads give zero.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= '0;
			if (rd_any && bank_hit) begin
				rdata_r <= {DIR_READ, reg_addr_i, entry_r[bank_sel]};
			end else if (reg_read_i && reg_addr_i == OFF_STATUS) begin
				rdata_r <= {11'h000, ptr};
			end
		end
	end

	assign reg_rdata_o = rdata_r;

	// A frame whose address field disagrees is dropped and flagged.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			mismatch_r <= 1'b0;
		end else begin
			mismatch_r <= bad_frame;
		end
	end

	assign address_mismatch_o = mismatch_r;

	// ------------------------------------------------------------------
	// Sequencer step
	// ------------------------------------------------------------------
	// Entries outside this bank come from the rest of the stack.
	assign ptr_in_bank = ptr >= BANK_FIRST && ptr <= BANK_LAST;
	assign ptr_sel     = 2'(ptr - BANK_FIRST);
	assign cur_entry   = ptr_in_bank ? entry_r[ptr_sel]
		: {other_return_flag_i, other_chan_b_i, other_chan_a_i};

	assign step.conv_done   = conversion_done_i;
	assign step.return_flag = cur_entry[RET_BIT];

	cssr_step_ptr #(
		.DEPTH (STACK_DEPTH)
	) u_step_ptr (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.step    (step.ptr_end)
	);

	assign ptr             = step.ptr;
	assign stack_pointer_o = ptr;

	// Channel selects are registered so the converters see clean levels;
	// they lag the pointer by one cycle.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			chan_a_r <= '0;
			chan_b_r <= '0;
		end else begin
			chan_a_r <= cur_entry[CHA_HI:CHA_LO];
			chan_b_r <= cur_entry[CHB_HI:CHB_LO];
		end
	end

	assign converter_a_channel_select_o = chan_a_r;
	assign converter_b_channel_select_o = chan_b_r;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence step_write_s;
		reg_write_i && bank_hit && reg_wdata_i[DIR_BIT]
			&& reg_wdata_i[TADDR_HI:TADDR_LO] == reg_addr_i;
	endsequence

	sequence step_read_frame_s;
		reg_write_i && bank_hit && !reg_wdata_i[DIR_BIT]
			&& reg_wdata_i[TADDR_HI:TADDR_LO] == reg_addr_i;
	endsequence

	sequence wrong_field_s;
		reg_write_i && bank_hit && reg_wdata_i[TADDR_HI:TADDR_LO] != reg_addr_i;
	endsequence

	write_store_a: assert property (@(posedge clock_i) disable iff (reset_i)
		step_write_s |=> entry_r[$past(bank_sel)] == $past(reg_wdata_i[ENTRY_W-1:0]))
		else $error("Write frame did not update the stack entry.");

	read_frame_a: assert property (@(posedge clock_i) disable iff (reset_i)
		step_read_frame_s |=> entry_r[$past(bank_sel)] == $past(entry_r[bank_sel])
			&& reg_rdata_o[ENTRY_W-1:0] == entry_r[$past(bank_sel)])
		else $error("Read frame changed or failed to return the entry.");

	field_guard_a: assert property (@(posedge clock_i) disable iff (reset_i)
		wrong_field_s |=> entry_r[$past(bank_sel)] == $past(entry_r[bank_sel])
			&& address_mismatch_o)
		else $error("Frame with a wrong address field was not dropped.");

	addr_readback_a: assert property (@(posedge clock_i) disable iff (reset_i)
		reg_read_i && bank_hit |=>
			reg_rdata_o[TADDR_HI:TADDR_LO] == $past(reg_addr_i) && !reg_rdata_o[DIR_BIT])
		else $error("Address field did not read back the register address.");

	rdata_pulse_a: assert property (@(posedge clock_i) disable iff (reset_i)
		!reg_read_i && !reg_write_i |=> reg_rdata_o == '0)
		else $error("Read data stood longer than one cycle.");

	chan_b_follow_a: assert property (@(posedge clock_i) disable iff (reset_i)
		ptr_in_bank ##1 1'b1 |->
			converter_b_channel_select_o == $past(entry_r[ptr_sel][CHB_HI:CHB_LO]))
		else $error("Converter B select does not follow the current entry.");

	chan_a_follow_a: assert property (@(posedge clock_i) disable iff (reset_i)
		ptr_in_bank ##1 1'b1 |->
			converter_a_channel_select_o == $past(entry_r[ptr_sel][CHA_HI:CHA_LO]))
		else $error("Converter A select does not follow the current entry.");

	seven_reset_a: assert property (@(posedge clock_i)
		reset_i |=> entry_r[1] == 9'h177 && entry_r[1][RET_BIT])
		else $error("Step seven reset value wrong.");

	eight_nine_reset_a: assert property (@(posedge clock_i)
		reset_i |=> entry_r[2] == 9'h000 && entry_r[3] == 9'h000)
		else $error("Steps eight and nine reset values wrong.");

	return_wrap_a: assert property (@(posedge clock_i) disable iff (reset_i)
		conversion_done_i && ptr_in_bank && entry_r[ptr_sel][RET_BIT]
			|=> stack_pointer_o == '0
			##1 converter_a_channel_select_o == $past(other_chan_a_i))
		else $error("Pointer did not wrap on a set return flag.");

	start_entry_a: assert property (@(posedge clock_i)
		reset_i ##1 !reset_i |-> stack_pointer_o == '0)
		else $error("Pointer not at the first entry after reset.");

	// The mismatch pulse must have a wrong address field behind it.
	mismatch_cause_a: assert property (@(posedge clock_i) disable iff (reset_i)
		!bad_frame |=> !address_mismatch_o)
		else $error("Address mismatch flagged without a wrong address field.");

	status_read_a: assert property (@(posedge clock_i) disable iff (reset_i)
		reg_read_i && reg_addr_i == OFF_STATUS |=> reg_rdata_o == {11'h000, $past(ptr)})
		else $error("Status read did not return the stack pointer.");

	// Entries outside the bank must reach the converters from the side inputs.
	out_chan_b_a: assert property (@(posedge clock_i) disable iff (reset_i)
		!ptr_in_bank |=> converter_b_channel_select_o == $past(other_chan_b_i))
		else $error("Converter B select ignores an entry outside the bank.");

	out_chan_a_a: assert property (@(posedge clock_i) disable iff (reset_i)
		!ptr_in_bank |=> converter_a_channel_select_o == $past(other_chan_a_i))
		else $error("Converter A select ignores an entry outside the bank.");

endmodule : cssr_regs

`default_nettype wire

// file: testbench/cssr_host_model.sv
// Host controller model that reaches the stack registers over the plain register port.
`default_nettype none

module cssr_host_model
	import cssr_pkg::*;
(
	input  wire logic                        clock_i,
	input  wire logic [cssr_pkg::DATA_W-1:0] reg_rdata_i,
	output var logic  [cssr_pkg::ADDR_W-1:0] reg_addr_o,
	output var logic  [cssr_pkg::DATA_W-1:0] reg_wdata_o,
	output var logic                         reg_write_o,
	output var logic                         reg_read_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// Idle state
	// ------------------------------------------------------------------
	// Strobes start low so nothing is taken while reset is still applied.
	initial begin
		reg_addr_o  = '0;
		reg_wdata_o = '0;
		reg_write_o = 1'b0;
		reg_read_o  = 1'b0;
	end

	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	// One write cycle; the word carries the direction bit and the address field.
	// Address and data are inverted once idle, so a slave that samples late sees junk.
	task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
		@(posedge clock_i);
		reg_addr_o  <= a;
		reg_wdata_o <= w;
		reg_write_o <= 1'b1;
		@(posedge clock_i);
		reg_write_o <= 1'b0;
		reg_addr_o  <= ~a;
		reg_wdata_o <= ~w;
		#1;
	endtask

	// One read cycle; the data are taken in the single cycle after the strobe.
	task automatic read_word(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clock_i);
		reg_addr_o <= a;
		reg_read_o <= 1'b1;
		@(posedge clock_i);
		reg_read_o <= 1'b0;
		reg_addr_o <= ~a;
		#1;
		d = reg_rdata_i;
	endtask

endmodule // cssr_host_model

`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the sequencer stack register bank.
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cssr_pkg::*;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic              clock_i = 1'b0;
	logic              reset_i = 1'b1;
	logic              conversion_done_i = 1'b0;
	logic              other_return_flag_i = 1'b0;
	logic [3:0]        other_chan_a_i = 4'h0;
	logic [3:0]        other_chan_b_i = 4'h0;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_write;
	logic              reg_read;
	logic [DATA_W-1:0] reg_rdata;
	logic [PTR_W-1:0]  stack_pointer;
	logic [3:0]        chan_a;
	logic [3:0]        chan_b;
	logic              mismatch;
	logic [DATA_W-1:0] exp_w [BANK_N];
	logic [PTR_W-1:0]  ptr_m;
	logic [DATA_W-1:0] rd;
	logic [31:0]       seed = 32'h98a0;
	int                n_errors = 0;
	int                checked = 0;

	// The clock toggles every half period of 12.5 ns, a period of 25 ns.
	always #12.5 clock_i = ~clock_i;

	// ------------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------------
	cssr_host_model host (
		.clock_i(clock_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
		.reg_wdata_o(reg_wdata), .reg_write_o(reg_write), .reg_read_o(reg_read)
	);

	cssr_regs dut (
		.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
		.reg_rdata_o(reg_rdata), .conversion_done_i(conversion_done_i),
		.other_return_flag_i(other_return_flag_i), .other_chan_a_i(other_chan_a_i),
		.other_chan_b_i(other_chan_b_i), .stack_pointer_o(stack_pointer),
		.converter_a_channel_select_o(chan_a), .converter_b_channel_select_o(chan_b),
		.address_mismatch_o(mismatch)
	);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Xorshift keeps the run repeatable without the simulator's own generator.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Steps the sequencer n times and follows it with a reference pointer.
	// Entries outside the bank come from random side inputs; their flag is random only if rf.
	task automatic seq_run(input int n, input bit rf);
		logic [31:0] t;
		logic        flag;
		logic [7:0]  chans;
		for (int i = 0; i < n; i++) begin
			t = rnd();
			@(posedge clock_i);
			other_chan_a_i      <= t[3:0];
			other_chan_b_i      <= t[7:4];
			other_return_flag_i <= rf && (t[10:8] == 3'h0);
			conversion_done_i   <= 1'b1;
			flag = (ptr_m >= BANK_FIRST && ptr_m <= BANK_LAST) ?
				exp_w[ptr_m - BANK_FIRST][8] : (rf && (t[10:8] == 3'h0));
			ptr_m = flag ? 5'h00 : ptr_m + 5'h01;
			@(posedge clock_i);
			conversion_done_i <= 1'b0;
			#1;
			`CHK("stack pointer", ptr_m, stack_pointer)
			@(posedge clock_i);
			#1;
			chans = (ptr_m >= BANK_FIRST && ptr_m <= BANK_LAST) ?
				exp_w[ptr_m - BANK_FIRST][7:0] : t[7:0];
			`CHK("converter b channel", chans[7:4], chan_b)
			`CHK("converter a channel", chans[3:0], chan_a)
		end
	endtask

	// Reads the four entries back and compares them with the reference words.
	task automatic read_all();
		for (int i = 0; i < BANK_N; i++) begin
			host.read_word(6'(OFF_STEP_SIX + i), rd);
			`CHK("entry word", exp_w[i], rd)
		end
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [31:0] t;
		logic [5:0]  a;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		#1;
		ptr_m = 5'h00;
		for (int i = 0; i < BANK_N; i++) exp_w[i] = RST_VALS[i];
		`CHK("pointer after reset", 5'h00, stack_pointer)
		host.read_word(OFF_STEP_SEVEN, rd);
		`CHK("step seven reset", 16'h4f77, rd)
		host.read_word(OFF_STEP_EIGHT, rd);
		`CHK("step eight reset", 16'h5000, rd)
		host.read_word(OFF_STEP_NINE, rd);
		`CHK("step nine reset", 16'h5200, rd)
		// Default contents: steps through six and seven, then wraps from seven.
		seq_run(10, 1'b0);
		for (int i = 0; i < 8; i++) begin
			t = rnd();
			a = 6'(OFF_STEP_SIX + t[1:0]);
			host.write_word(a, {DIR_WRITE, a, t[12:4]});
			exp_w[t[1:0]] = {DIR_READ, a, t[12:4]};
			`CHK("no mismatch", 1'b0, mismatch)
		end
		read_all();
		// A wrong address field is refused and flagged, contents untouched.
		host.write_word(OFF_STEP_EIGHT, {DIR_WRITE, OFF_STEP_NINE, 9'h1ff});
		`CHK("mismatch pulse", 1'b1, mismatch)
		// Direction clear asks for a read: data follow, nothing is stored.
		host.write_word(OFF_STEP_SEVEN, {DIR_READ, OFF_STEP_SEVEN, 9'h0aa});
		`CHK("read request data", exp_w[1], reg_rdata)
		read_all();
		host.read_word(6'h3f, rd);
		`CHK("unmapped read", 16'h0000, rd)
		host.read_word(OFF_STATUS, rd);
		`CHK("status pointer", {11'h000, ptr_m}, rd)
		// A reset in mid-run must restore the default words over the written ones.
		@(posedge clock_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		#1;
		ptr_m = 5'h00;
		for (int i = 0; i < BANK_N; i++) exp_w[i] = RST_VALS[i];
		`CHK("pointer after second reset", 5'h00, stack_pointer)
		read_all();
		seq_run(40, 1'b1);
		end_of_test();
	end

	// Cuts a hang short well beyond the few hundred cycles the run needs.
	initial begin
		repeat (5000) @(posedge clock_i);
		n_errors++;
		end_of_test();
	end

endmodule // tb_top

`default_nettype wire
